/* hw/sad_defines.vh */
/*
 Register map, field positions, reset values, codes and timing counts of the
 converter sequencer. Assumes inclusion by bare name from the design file.
*/
`ifndef SAD_DEFINES_VH
`define SAD_DEFINES_VH

// byte addresses on the register bus, and the buffer select in address bits 7:6
`define SAD_ADDR_CTRL_ONE 8'h00
`define SAD_ADDR_CTRL_TWO 8'h04
`define SAD_ADDR_CTRL_THREE 8'h08
`define SAD_BUF_SEL 2'h1

// control one fields
`define SAD_ON_BIT 15
`define SAD_IDLE_BIT 13
`define SAD_RES_BIT 10
`define SAD_FMT_HI 9
`define SAD_FMT_LO 8
`define SAD_SRC_HI 7
`define SAD_SRC_LO 5
`define SAD_SIM_BIT 3
`define SAD_AUTO_SAMPLE_START_BIT 2
`define SAD_SAMPLING_FLAG_BIT 1
`define SAD_DONE_BIT 0

// control two and three fields
`define SAD_CHPS_HI 9
`define SAD_CHPS_LO 8
`define SAD_SMPI_HI 5
`define SAD_SMPI_LO 2
`define SAD_SAMC_HI 12
`define SAD_SAMC_LO 8

// reset values
`define SAD_CTRL_ONE_RST 16'h0000
`define SAD_CTRL_TWO_RST 16'h0000
`define SAD_CTRL_THREE_RST 16'h0000

// trigger source and format codes
`define SAD_SRC_SOFT 3'h0
`define SAD_SRC_EXT 3'h1
`define SAD_SRC_TMR 3'h2
`define SAD_SRC_AUTO 3'h7
`define SAD_FMT_SIGNED 2'h1

// conversion clock period and its cycle count at the system clock
`define SAD_TAD_NS 40
`define SAD_CLK_NS 10
`define SAD_TAD_CYCLES ((`SAD_TAD_NS + `SAD_CLK_NS - 1) / `SAD_CLK_NS)

// bus responses
`define SAD_RESP_OKAY 2'h0
`define SAD_RESP_SLVERR 2'h2

`endif

/* hw/sad_sequencer.v */
/*
 Sequencer of a successive-approximation converter: control registers over
 AXI4-Lite, sample/convert state machine, result formatting, 16-word buffer.
 Assumes a SAR core on aclk that answers each sar_start with one sar_done
 pulse carrying sar_result; idle_mode and timer3_match are on aclk.
*/
`timescale 1ns/1ps
`include "sad_defines.vh"

module sad_sequencer (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // trigger sources and the idle-mode stop input
   input wire idle_mode,
   input wire timer3_match,
   input wire ext_irq_pin_zero,
   // sample-and-hold front end and sar core
   output wire [3:0] sh_acquire,
   output wire sar_start,
   output wire [1:0] sar_channel,
   output wire sar_res12,
   input wire sar_done,
   input wire [11:0] sar_result,
   // sequence count event
   output wire seq_event
);

   localparam [2:0] ST_OFF = 3'h0;
   localparam [2:0] ST_HOLD = 3'h1;
   localparam [2:0] ST_SAMPLE = 3'h2;
   localparam [2:0] ST_START = 3'h3;
   localparam [2:0] ST_WAIT = 3'h4;
   localparam integer TAD_CYC = `SAD_TAD_CYCLES - 1;
   localparam [7:0] TAD_LAST = TAD_CYC[7:0];
   localparam [15:0] CTRL_ONE_RST = `SAD_CTRL_ONE_RST;

   // bus state
   reg aw_held_ff;
   reg [7:0] awaddr_ff;
   reg w_held_ff;
   reg [31:0] wdata_ff;
   reg [3:0] wstrb_ff;
   reg bvalid_ff;
   reg [1:0] bresp_ff;
   reg rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0] rresp_ff;

   // control fields
   reg on_ff;
   reg idle_stop_ff;
   reg res_ff;
   reg [1:0] fmt_ff;
   reg [2:0] src_ff;
   reg sim_ff;
   reg auto_sample_start_ff;
   reg sampling_flag_ff;
   reg done_ff;
   reg [1:0] chps_ff;
   reg [3:0] smpi_ff;
   reg [4:0] samc_ff;

   // sequencer state
   reg [2:0] state_ff;
   reg [1:0] ch_ff;
   reg [7:0] tad_cnt_ff;
   reg [4:0] samc_cnt_ff;
   reg [3:0] seq_cnt_ff;
   reg [3:0] wr_ptr_ff;
   reg sar_start_ff;
   reg seq_event_ff;
   reg [15:0] result_buf [0:15];

   // external pin synchroniser and filter
   reg pin_s1_ff;
   reg pin_s2_ff;
   reg pin_s3_ff;
   reg pin_lvl_ff;

   wire wr_en = aw_held_ff && w_held_ff && !bvalid_ff;
   wire wr_one = wr_en && (awaddr_ff == `SAD_ADDR_CTRL_ONE);
   wire wr_two = wr_en && (awaddr_ff == `SAD_ADDR_CTRL_TWO);
   wire wr_three = wr_en && (awaddr_ff == `SAD_ADDR_CTRL_THREE);
   wire wr_map = wr_one || wr_two || wr_three;
   wire run = on_ff && !(idle_stop_ff && idle_mode);
   wire sim_eff = sim_ff && !res_ff;
   wire [1:0] chps_eff = res_ff ? 2'h0 : chps_ff;
   wire [1:0] last_ch = chps_eff[1] ? 2'h3 : (chps_eff[0] ? 2'h1 : 2'h0);
   wire converting = (state_ff == ST_START) || (state_ff == ST_WAIT);
   wire pin_edge = (pin_s2_ff == pin_s3_ff) && pin_s3_ff && !pin_lvl_ff;
   wire sw_sampling_flag_one = wr_one && wstrb_ff[0] && wdata_ff[`SAD_SAMPLING_FLAG_BIT];
   wire sw_sampling_flag_zero = wr_one && wstrb_ff[0] && !wdata_ff[`SAD_SAMPLING_FLAG_BIT];
   wire buf_we = run && (state_ff == ST_WAIT) && sar_done;
   reg end_sampling_flag;
   reg [15:0] fmt_result;
   reg [31:0] rd_mux;
   reg [1:0] rd_resp;

   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready = !w_held_ff && !bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign sar_start = sar_start_ff;
   assign sar_channel = ch_ff;
   assign sar_res12 = res_ff;
   assign seq_event = seq_event_ff;

   // channels not yet converted keep acquiring when sampling sequentially
   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_sh
         localparam integer KI = k;
         localparam [1:0] KK = KI[1:0];
         assign sh_acquire[k] = (KK <= last_ch) &&
            (sampling_flag_ff || (!sim_eff && converting && (KK > ch_ff)));
      end
   endgenerate

   always @* begin
      case (src_ff)
         `SAD_SRC_AUTO: end_sampling_flag = (samc_cnt_ff == samc_ff);
         `SAD_SRC_TMR: end_sampling_flag = timer3_match;
         `SAD_SRC_EXT: end_sampling_flag = pin_edge;
         `SAD_SRC_SOFT: end_sampling_flag = sw_sampling_flag_zero;
         default: end_sampling_flag = 1'b0;
      endcase
   end

   always @* begin
      fmt_result = 16'h0000;
      if (res_ff) begin
         if (fmt_ff == `SAD_FMT_SIGNED)
            fmt_result = {{4{~sar_result[11]}}, sar_result};
         else
            fmt_result = {4'h0, sar_result};
      end else begin
         if (fmt_ff == `SAD_FMT_SIGNED)
            fmt_result = {{6{~sar_result[9]}}, sar_result[9:0]};
         else
            fmt_result = {6'h00, sar_result[9:0]};
      end
   end

   always @* begin
      rd_mux = 32'h00000000;
      rd_resp = `SAD_RESP_OKAY;
      if (s_axi_araddr[7:6] == `SAD_BUF_SEL) begin
         rd_mux = {16'h0000, result_buf[s_axi_araddr[5:2]]};
      end else begin
         case (s_axi_araddr)
            `SAD_ADDR_CTRL_ONE: rd_mux = {16'h0000, on_ff, 1'b0, idle_stop_ff, 2'h0, res_ff, fmt_ff,
               src_ff, 1'b0, sim_eff, auto_sample_start_ff, sampling_flag_ff, done_ff};
            `SAD_ADDR_CTRL_TWO: rd_mux = {22'h000000, chps_eff, 2'h0, smpi_ff, 2'h0};
            `SAD_ADDR_CTRL_THREE: rd_mux = {19'h00000, samc_ff, 8'h00};
            default: rd_resp = `SAD_RESP_SLVERR;
         endcase
      end
   end

   // bus handshakes
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         w_held_ff <= 1'b0;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `SAD_RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= `SAD_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_en) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_map ? `SAD_RESP_OKAY : `SAD_RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_resp;
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // pin passes three flops; level counts once the last two agree
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         pin_s3_ff <= 1'b0;
         pin_lvl_ff <= 1'b0;
      end else begin
         pin_s1_ff <= ext_irq_pin_zero;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         if (pin_s2_ff == pin_s3_ff)
            pin_lvl_ff <= pin_s3_ff;
      end
   end

   // buffer has no reset; contents are undefined until first written
   always @(posedge aclk) begin
      if (buf_we)
         result_buf[wr_ptr_ff] <= fmt_result;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         on_ff <= CTRL_ONE_RST[`SAD_ON_BIT];
         idle_stop_ff <= 1'b0;
         res_ff <= 1'b0;
         fmt_ff <= 2'h0;
         src_ff <= 3'h0;
         sim_ff <= 1'b0;
         auto_sample_start_ff <= 1'b0;
         sampling_flag_ff <= 1'b0;
         done_ff <= 1'b0;
         chps_ff <= 2'h0;
         smpi_ff <= 4'h0;
         samc_ff <= 5'h00;
         state_ff <= ST_OFF;
         ch_ff <= 2'h0;
         tad_cnt_ff <= 8'h00;
         samc_cnt_ff <= 5'h00;
         seq_cnt_ff <= 4'h0;
         wr_ptr_ff <= 4'h0;
         sar_start_ff <= 1'b0;
         seq_event_ff <= 1'b0;
      end else begin
         sar_start_ff <= 1'b0;
         seq_event_ff <= 1'b0;
         if (wr_one && wstrb_ff[1]) begin
            on_ff <= wdata_ff[`SAD_ON_BIT];
            idle_stop_ff <= wdata_ff[`SAD_IDLE_BIT];
            res_ff <= wdata_ff[`SAD_RES_BIT];
            fmt_ff <= wdata_ff[`SAD_FMT_HI:`SAD_FMT_LO];
         end
         if (wr_one && wstrb_ff[0]) begin
            src_ff <= wdata_ff[`SAD_SRC_HI:`SAD_SRC_LO];
            sim_ff <= wdata_ff[`SAD_SIM_BIT];
            auto_sample_start_ff <= wdata_ff[`SAD_AUTO_SAMPLE_START_BIT];
            if (!wdata_ff[`SAD_DONE_BIT])
               done_ff <= 1'b0;
         end
         if (wr_two && wstrb_ff[1])
            chps_ff <= wdata_ff[`SAD_CHPS_HI:`SAD_CHPS_LO];
         if (wr_two && wstrb_ff[0])
            smpi_ff <= wdata_ff[`SAD_SMPI_HI:`SAD_SMPI_LO];
         if (wr_three && wstrb_ff[1])
            samc_ff <= wdata_ff[`SAD_SAMC_HI:`SAD_SAMC_LO];
         // hardware done set below comes later, so it wins over a clear
         case (state_ff)
            ST_OFF: begin
               sampling_flag_ff <= 1'b0;
               if (run)
                  state_ff <= ST_HOLD;
            end
            ST_HOLD: begin
               if (auto_sample_start_ff || sw_sampling_flag_one) begin
                  sampling_flag_ff <= 1'b1;
                  tad_cnt_ff <= 8'h00;
                  samc_cnt_ff <= 5'h00;
                  state_ff <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               if (tad_cnt_ff == TAD_LAST) begin
                  tad_cnt_ff <= 8'h00;
                  if (samc_cnt_ff != samc_ff)
                     samc_cnt_ff <= samc_cnt_ff + 5'h01;
               end else begin
                  tad_cnt_ff <= tad_cnt_ff + 8'h01;
               end
               if (end_sampling_flag) begin
                  sampling_flag_ff <= 1'b0;
                  done_ff <= 1'b0;
                  ch_ff <= 2'h0;
                  state_ff <= ST_START;
               end
            end
            ST_START: begin
               sar_start_ff <= 1'b1;
               state_ff <= ST_WAIT;
            end
            ST_WAIT: begin
               if (sar_done) begin
                  wr_ptr_ff <= wr_ptr_ff + 4'h1;
                  if (ch_ff == last_ch) begin
                     done_ff <= 1'b1;
                     if (seq_cnt_ff == smpi_ff) begin
                        seq_cnt_ff <= 4'h0;
                        seq_event_ff <= 1'b1;
                        wr_ptr_ff <= 4'h0;
                     end else begin
                        seq_cnt_ff <= seq_cnt_ff + 4'h1;
                     end
                     if (auto_sample_start_ff) begin
                        sampling_flag_ff <= 1'b1;
                        tad_cnt_ff <= 8'h00;
                        samc_cnt_ff <= 5'h00;
                        state_ff <= ST_SAMPLE;
                     end else begin
                        state_ff <= ST_HOLD;
                     end
                  end else begin
                     ch_ff <= ch_ff + 2'h1;
                     state_ff <= ST_START;
                  end
               end
            end
            default: state_ff <= ST_OFF;
         endcase
         if (!run) begin
            state_ff <= ST_OFF;
            sampling_flag_ff <= 1'b0;
            ch_ff <= 2'h0;
            sar_start_ff <= 1'b0;
         end
      end
   end

endmodule // sad_sequencer

/* dv/sad_sequencer_props.sv */
/*
 Port-level properties of the converter sequencer.
 Assumes one aclk domain and aresetn synchronous, active low.
*/
`timescale 1ns/1ps
module sad_sequencer_props (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // register bus
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // converter side
   input wire [3:0] sh_acquire,
   input wire sar_start,
   input wire [1:0] sar_channel,
   input wire sar_res12,
   input wire sar_done,
   input wire seq_event
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
   sequence s_next_step; sar_start && sar_channel != 2'h0; endsequence
   property p_b_stands; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_stands: assert property (p_b_stands) else $error("write response dropped early");
   property p_r_stands; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_stands: assert property (p_r_stands) else $error("read data dropped early");
   property p_r_answer; s_ar_taken |=> s_axi_rvalid; endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_seq_pulse; seq_event |=> !seq_event; endproperty
   a_seq_pulse: assert property (p_seq_pulse) else $error("sequence event too long");
   property p_start_pulse; sar_start |=> !sar_start; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
   property p_one_sh; sar_res12 |-> sh_acquire[3:1] == 3'h0; endproperty
   a_one_sh: assert property (p_one_sh) else $error("extra sample-and-hold in 12-bit mode");
   property p_res12_ch; sar_res12 && sar_start |-> sar_channel == 2'h0; endproperty
   a_res12_ch: assert property (p_res12_ch) else $error("channel beyond zero in 12-bit mode");
   property p_conv_holds; sar_start |-> !sh_acquire[sar_channel]; endproperty
   a_conv_holds: assert property (p_conv_holds) else $error("converted channel still acquiring");
   property p_chan_order;
      s_next_step |-> $past(sar_done, 2) && sar_channel == $past(sar_channel, 2) + 2'h1;
   endproperty
   a_chan_order: assert property (p_chan_order) else $error("channel order broken");
endmodule // sad_sequencer_props

bind sad_sequencer sad_sequencer_props chk_u (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .sh_acquire, .sar_start, .sar_channel, .sar_res12, .sar_done, .seq_event);

/* dv/sad_sar_model.sv */
/*
 Behavioural sar core: one done pulse per start, prompt or slow.
 Assumes aclk and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module sad_sar_model (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // sequencer side
   input logic sar_start,
   input logic [1:0] sar_channel,
   input logic sar_res12,
   output logic sar_done,
   output logic [11:0] sar_result,
   // bench controls
   input logic [11:0] base,
   input logic slow
);
   logic [3:0] cnt_ff;
   logic [11:0] val_ff;
   // result toggles outside the done cycle so a stale capture shows up
   always @(posedge aclk) begin
      sar_done <= 1'b0;
      sar_result <= ~sar_result;
      if (!aresetn) begin
         cnt_ff <= 4'h0;
         sar_result <= 12'h000;
      end else if (sar_start) begin
         val_ff <= (base + sar_channel * 12'h111) & (sar_res12 ? 12'hFFF : 12'h3FF);
         cnt_ff <= slow ? 4'h9 : 4'h1;
      end else if (cnt_ff == 4'h1) begin
         sar_done <= 1'b1;
         sar_result <= val_ff;
         cnt_ff <= 4'h0;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end
endmodule // sad_sar_model

/* dv/sad_sequencer_tb.sv */
/*
 Bench of the converter sequencer: bus tasks, a result model, scenarios.
 Assumes the sar model and the bound checker beside it.
*/
`timescale 1ns/1ps
`include "sad_defines.vh"
module sad_sequencer_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, c1, ce;
   logic [3:0] s_axi_wstrb, sh_acquire;
   logic [1:0] s_axi_bresp, s_axi_rresp, sar_channel, r, fmt, chps;
   logic idle_mode, timer3_match, ext_irq_pin_zero, sar_start, sar_res12, sar_done, seq_event;
   logic slow, res, sim, smpi;
   logic [11:0] sar_result, base;
   logic [2:0] src;
   logic [2:0] srcs [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
   int errors, total_checks, cyc, ev, i, k, n, ptr, sq, t;

   sad_sequencer dut_u (.*);
   sad_sar_model sar_u (.*);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
      chk({30'h0, got}, {30'h0, exp});
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w, b;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid === 1'b1;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic ar, ok;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ok = 1'b0;
      while (!ok) begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         ok = s_axi_rvalid === 1'b1;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic wait_done;
      d = 0;
      for (t = 0; t < 300 && d[1:0] !== 2'b01; t++) rd(`SAD_ADDR_CTRL_ONE);
   endtask
   function automatic logic [31:0] fmt_of(input logic [11:0] v, input logic r12, input logic [1:0] f);
      if (r12) return {16'h0, (f == 2'h1) ? {4{~v[11]}} : 4'h0, v};
      return {16'h0, (f == 2'h1) ? {6{~v[9]}} : 6'h0, v[9:0]};
   endfunction

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (seq_event === 1'b1) ev++;
      if (cyc == 40000) begin
         errors++;
         wrap_up;
      end
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {idle_mode, timer3_match, ext_irq_pin_zero, slow} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, base} = 60'h0;
      s_axi_wstrb = 4'hF;
      k = $urandom(32'h938802AA);
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (k = 0; k < 3; k++) begin
         rd(8'(4 * k));
         chk(d, 32'h0);
      end
      rd(8'h20);
      chk(d, 32'h0);
      chk_rsp(r, `SAD_RESP_SLVERR);
      wr(8'h40, 32'h1234);
      chk_rsp(r, `SAD_RESP_SLVERR);
      for (i = 0; i < 10; i++) begin
         res = (i < 8) && i[2];
         fmt = (i < 8) ? i[1:0] : 2'h1;
         chps = (i < 8) ? i[1:0] : 2'h3;
         src = (i < 8) ? srcs[i[1:0]] : 3'h0;
         sim = i[1] ^ i[0];
         smpi = (i >= 8);
         base <= 12'($urandom);
         slow <= 1'($urandom);
         n = res ? 1 : (chps == 2'h0) ? 1 : (chps == 2'h1) ? 2 : 4;
         c1 = 32'h8000 | (res << 10) | (fmt << 8) | (src << 5) | (sim << 3);
         ce = res ? c1 & ~32'h8 : c1;
         // the sequence counter must survive into the second paired run
         if (i != 9) wr(`SAD_ADDR_CTRL_ONE, c1 & ~32'h8000);
         wr(`SAD_ADDR_CTRL_TWO, (chps << 8) | (smpi << 2));
         wr(`SAD_ADDR_CTRL_THREE, 32'($urandom_range(31, 8)) << 8);
         rd(`SAD_ADDR_CTRL_TWO);
         chk(d, ((res ? 2'h0 : chps) << 8) | (smpi << 2));
         wr(`SAD_ADDR_CTRL_ONE, c1);
         wr(`SAD_ADDR_CTRL_ONE, c1 | 32'h2);
         rd(`SAD_ADDR_CTRL_ONE);
         chk(d, ce | 32'h2);
         @(negedge aclk);
         chk({28'h0, sh_acquire}, (32'h1 << n) - 1);
         case (src)
            3'h0: wr(`SAD_ADDR_CTRL_ONE, c1);
            3'h1: begin
               @(posedge aclk);
               ext_irq_pin_zero <= 1'b1;
               repeat (6) @(posedge aclk);
               ext_irq_pin_zero <= 1'b0;
            end
            3'h2: begin
               @(posedge aclk);
               timer3_match <= 1'b1;
               @(posedge aclk);
               timer3_match <= 1'b0;
            end
            default: ;
         endcase
         wait_done;
         chk(d, ce | 32'h1);
         chk({31'h0, sar_res12}, {31'h0, res});
         for (k = 0; k < n; k++) begin
            rd(8'h40 + 8'(4 * ((ptr + k) % 16)));
            chk(d, fmt_of(base + 12'(k) * 12'h111, res, fmt));
         end
         sq++;
         if (sq > smpi) {sq, ptr} = 0;
         else ptr = (ptr + n) % 16;
         wr(`SAD_ADDR_CTRL_ONE, c1);
         rd(`SAD_ADDR_CTRL_ONE);
         chk(d, ce);
         wr(`SAD_ADDR_CTRL_ONE, c1 | 32'h1);
         rd(`SAD_ADDR_CTRL_ONE);
         chk(d, ce);
         // off with the resolution untouched, so it is never changed while on
         if (i != 8) wr(`SAD_ADDR_CTRL_ONE, c1 & ~32'h8000);
      end
      chk(ev, 9);
      wr(`SAD_ADDR_CTRL_THREE, 32'h1F00);
      wr(`SAD_ADDR_CTRL_TWO, 32'h0);
      wr(`SAD_ADDR_CTRL_ONE, 32'h80E4);
      wait_done;
      for (t = 0; t < 300 && d[0] !== 1'b1; t++) rd(`SAD_ADDR_CTRL_ONE);
      chk(d & 32'h3, 32'h3);
      // slow answers widen the holding window so a poll can see it
      slow <= 1'b1;
      for (t = 0; t < 300 && d[1] !== 1'b0; t++) rd(`SAD_ADDR_CTRL_ONE);
      chk(d & 32'h3, 32'h0);
      idle_mode <= 1'b1;
      for (t = 0; t < 300 && d[0] !== 1'b1; t++) rd(`SAD_ADDR_CTRL_ONE);
      chk(d & 32'h3, 32'h3);
      wr(`SAD_ADDR_CTRL_ONE, 32'hA0E4);
      idle_mode <= 1'b1;
      rd(`SAD_ADDR_CTRL_ONE);
      chk(d & 32'h2, 32'h0);
      wr(`SAD_ADDR_CTRL_ONE, 32'h00E4);
      idle_mode <= 1'b0;
      rd(`SAD_ADDR_CTRL_ONE);
      chk(d & 32'hFFFE, 32'h00E4);
      @(negedge aclk);
      chk({28'h0, sh_acquire}, 32'h0);
      wrap_up;
   end
endmodule // sad_sequencer_tb
